/* File: design/casr_dram.sv */
// dram end: command capture with chip select latency, receiver
// enable, mode registers and self refresh temperature mode
// assumes link driven by the controller on the same clock
`timescale 1ns/1ps
`default_nettype none
module casr_dram
   import casr_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   casr_if.dram link,
   input wire logic signed [7:0] temp_in,
   output logic cmd_valid_out,
   output casr_cmd_t cmd_out,
   output logic [BA_W-1:0] ba_out,
   output logic [ADDR_W-1:0] addr_out,
   output logic rx_en_out,
   output logic odt_out,
   output logic [CAL_W-1:0] cal_out,
   output casr_low_power_auto_refresh_mode_t low_power_auto_refresh_mode_mode_out,
   output logic self_refresh_out,
   output casr_rate_t sr_rate_out
);
   localparam int MAX_CAL = (1 << CAL_W) - 1;

   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_SREF = 2'b10
   } casr_sr_state_t;

   // ***********************************************
   // state
   // ***********************************************
   logic [MAX_CAL-1:0] pipe_reg;
   logic [MAX_CAL-1:0] pipe_next;
   logic [MAX_CAL-1:0] pend;
   logic [CAL_W-1:0] cal_reg;
   casr_low_power_auto_refresh_mode_t low_power_auto_refresh_mode_reg;
   casr_low_power_auto_refresh_mode_t sr_mode_reg;
   casr_sr_state_t state_reg;
   casr_sr_state_t state_next;
   logic cmd_valid_reg;
   casr_cmd_t cmd_reg;
   logic [BA_W-1:0] ba_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic odt_reg;
   casr_rate_t rate_reg;
   logic signed [7:0] temp_s1_reg;
   logic signed [7:0] temp_s2_reg;
   logic signed [7:0] temp_s3_reg;
   logic signed [7:0] temp_use_reg;

   // ***********************************************
   // capture decode
   // ***********************************************
   wire cs_low = ~link.cs_n;
   wire cal_on = (cal_reg != CAL_RESET);
   wire [CAL_W-1:0] hit_idx = cal_reg - CAL_W'(1);
   wire pipe_hit = cal_on && pipe_reg[hit_idx];
   wire capture = cal_on ? pipe_hit : cs_low; // RQ1 RQ14
   wire cap_mrs = capture && (link.cmd == CMD_MRS);
   wire wr_mr1 = cap_mrs && (link.ba == MR_ONE_SEL);
   wire wr_mr2 = cap_mrs && (link.ba == MR_TWO_SEL);
   wire cap_sre = capture && (link.cmd == CMD_SRE);
   wire cap_srx = capture && (link.cmd == CMD_SRX);
   wire [CAL_W-1:0] cal_field = link.addr[CAL_LSB +: CAL_W];
   wire [1:0] low_power_auto_refresh_mode_field = link.addr[LOW_POWER_AUTO_REFRESH_MODE_LSB +: 2];

   // cs lows still waiting for their capture edge keep receivers on
   genvar i;
   generate
      for (i = 0; i < MAX_CAL; i++) begin : g_pend
         assign pend[i] = pipe_reg[i] && (CAL_W'(i) < cal_reg);
      end
   endgenerate

   assign pipe_next = cal_on ? {pipe_reg[MAX_CAL-2:0], cs_low}
                             : '0;

   // receivers off only once every pending capture is done
   // and chip select is back high
   assign rx_en_out = ~cal_on | cs_low | (|pend); // RQ3 RQ4

   // ***********************************************
   // self refresh state and rate
   // ***********************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (cap_sre) begin
               state_next = ST_SREF;
            end
         end
         ST_SREF: begin
            if (cap_srx) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   // mode in force: latched at entry while refreshing
   wire in_sref = (state_reg == ST_SREF);
   wire casr_low_power_auto_refresh_mode_t mode_eff = in_sref ? sr_mode_reg : low_power_auto_refresh_mode_reg; // RQ11
   // a reading is used only once it has held for two samples, so a
   // word caught mid-change by the synchroniser never sets the rate
   wire temp_steady = (temp_s3_reg == temp_s2_reg);
   wire temp_cold = (temp_use_reg <= TEMP_COLD_MAX);
   wire temp_hot = (temp_use_reg > TEMP_NORMAL_MAX);
   wire casr_rate_t auto_rate = temp_cold ? RATE_LOW
                              : temp_hot ? RATE_HIGH
                              : RATE_NORMAL; // RQ10
   wire casr_rate_t rate_sel =
      (mode_eff == LOW_POWER_AUTO_REFRESH_MODE_AUTO) ? auto_rate // RQ9
      : (mode_eff == LOW_POWER_AUTO_REFRESH_MODE_EXTENDED) ? RATE_HIGH
      : (mode_eff == LOW_POWER_AUTO_REFRESH_MODE_REDUCED) ? RATE_LOW
      : RATE_NORMAL; // RQ13

   // ***********************************************
   // registers
   // ***********************************************
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         temp_s1_reg <= '0;
         temp_s2_reg <= '0;
         temp_s3_reg <= '0;
         temp_use_reg <= '0;
      end else if (ce_in) begin
         temp_s1_reg <= temp_in;
         temp_s2_reg <= temp_s1_reg;
         temp_s3_reg <= temp_s2_reg;
         if (temp_steady) begin
            temp_use_reg <= temp_s2_reg;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pipe_reg <= '0;
         cmd_valid_reg <= 1'b0;
         cmd_reg <= CMD_DES;
         ba_reg <= '0;
         addr_reg <= '0;
      end else if (ce_in) begin
         pipe_reg <= pipe_next;
         cmd_valid_reg <= capture;
         if (capture) begin
            cmd_reg <= link.cmd;
            ba_reg <= link.ba;
            addr_reg <= link.addr;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         cal_reg <= CAL_RESET;
         low_power_auto_refresh_mode_reg <= LOW_POWER_AUTO_REFRESH_MODE_NORMAL;
      end else if (ce_in) begin
         if (wr_mr1) begin
            cal_reg <= cal_field;
         end
         if (wr_mr2) begin
            low_power_auto_refresh_mode_reg <= casr_low_power_auto_refresh_mode_t'(low_power_auto_refresh_mode_field); // RQ13
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= ST_RUN;
         sr_mode_reg <= LOW_POWER_AUTO_REFRESH_MODE_NORMAL;
         rate_reg <= RATE_NORMAL;
      end else if (ce_in) begin
         state_reg <= state_next;
         if (cap_sre && !in_sref) begin
            sr_mode_reg <= low_power_auto_refresh_mode_reg; // RQ11
         end
         rate_reg <= rate_sel;
      end
   end

   // termination follows the pin with no latency added
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         odt_reg <= 1'b0;
      end else if (ce_in) begin
         odt_reg <= link.odt; // RQ8
      end
   end

   // ***********************************************
   // outputs
   // ***********************************************
   assign cmd_valid_out = cmd_valid_reg;
   assign cmd_out = cmd_reg;
   assign ba_out = ba_reg;
   assign addr_out = addr_reg;
   assign odt_out = odt_reg;
   assign cal_out = cal_reg;
   assign low_power_auto_refresh_mode_mode_out = low_power_auto_refresh_mode_reg;
   assign self_refresh_out = in_sref;
   assign sr_rate_out = rate_reg;
endmodule : casr_dram
`default_nettype wire

/* File: design/casr_pkg.sv */
// shared constants and types for the command latency / self refresh ends
// assumes both ends run on the one dram clock
// Behaviour
// RQ1: with latency on, capture after programmed delay
// RQ2: controller programs latency by mode command, rounded
// RQ3: receivers may turn off after capture, cs high
// RQ4: receivers stay on over consecutive commands
// RQ5: after mode command wait update plus latency
// RQ6: space mode commands by update plus latency
// RQ7: wait intervals use the newly written latency
// RQ8: termination timing unaffected by the latency
// RQ9: both temperature bits set selects automatic mode
// RQ10: automatic mode follows die temperature for rate
// RQ11: fixed mode programmed, applied at refresh entry
// RQ12: change temperature mode only outside self refresh
// RQ13: bit pairs: 00 normal 10 extended 01 reduced
// RQ14: latency off captures in the chip select cycle
package casr_pkg;
   // ***********************************************
   // bus and timing
   // ***********************************************
   localparam int CLK_PERIOD_PS = 8000;
   localparam int ADDR_W = 14;
   localparam int BA_W = 2;
   localparam int CAL_W = 3;
   localparam int WAIT_W = 8;
   localparam int CMD_ADDR_DELAY_TIME_PS = 3000;
   localparam int MODE_UPDATE_WAIT_CK = 24;
   // ***********************************************
   // mode register layout
   // ***********************************************
   localparam logic [BA_W-1:0] MR_ONE_SEL = 2'h1;
   localparam logic [BA_W-1:0] MR_TWO_SEL = 2'h2;
   localparam int CAL_LSB = 6;
   localparam int LOW_POWER_AUTO_REFRESH_MODE_LSB = 6;
   localparam logic [CAL_W-1:0] CAL_RESET = 3'h0;
   localparam logic signed [7:0] TEMP_COLD_MAX = 8'sh2D;
   localparam logic signed [7:0] TEMP_NORMAL_MAX = 8'sh55;
   typedef enum logic [2:0] {
      CMD_DES = 3'h0, CMD_MRS = 3'h1, CMD_REF = 3'h2, CMD_SRE = 3'h3,
      CMD_SRX = 3'h4, CMD_RD = 3'h5, CMD_WR = 3'h6, CMD_NOP = 3'h7
   } casr_cmd_t;
   typedef enum logic [1:0] {
      LOW_POWER_AUTO_REFRESH_MODE_NORMAL = 2'h0, LOW_POWER_AUTO_REFRESH_MODE_REDUCED = 2'h1,
      LOW_POWER_AUTO_REFRESH_MODE_EXTENDED = 2'h2, LOW_POWER_AUTO_REFRESH_MODE_AUTO = 2'h3
   } casr_low_power_auto_refresh_mode_t;
   typedef enum logic [2:0] {
      RATE_LOW = 3'h1, RATE_NORMAL = 3'h2, RATE_HIGH = 3'h4
   } casr_rate_t;
endpackage : casr_pkg

/* File: design/casr_if.sv */
// command/address link between controller and dram end
// assumes one shared clock; the bench joins the two ends with it
`timescale 1ns/1ps
`default_nettype none
interface casr_if;
   import casr_pkg::*;
   logic cs_n;
   casr_cmd_t cmd;
   logic [BA_W-1:0] ba;
   logic [ADDR_W-1:0] addr;
   logic odt;
   modport ctrl (output cs_n, output cmd, output ba, output addr,
      output odt);
   modport dram (input cs_n, input cmd, input ba, input addr, input odt);
endinterface : casr_if
`default_nettype wire

/* File: design/casr_ctrl.sv */
// controller end: issues commands with chip select latency and keeps
// mode command spacing and self refresh mode discipline
// assumes user requests and the dram end share clk_sys_in
`timescale 1ns/1ps
`default_nettype none
module casr_ctrl
   import casr_pkg::*;
#(
   parameter int CAL_TIME_PS = CMD_ADDR_DELAY_TIME_PS,
   parameter int MOD_CK = MODE_UPDATE_WAIT_CK
)
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   casr_if.ctrl link,
   input wire logic req_valid_in,
   input wire casr_cmd_t req_cmd_in,
   input wire logic [BA_W-1:0] req_ba_in,
   input wire logic [ADDR_W-1:0] req_addr_in,
   input wire logic cal_enable_in,
   input wire logic odt_in,
   output logic req_ready_out,
   output logic [CAL_W-1:0] cal_out,
   output logic self_refresh_out
);
   // least time rounds up to whole clocks
   localparam int CAL_CK_RAW = (CAL_TIME_PS + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
   localparam int CAL_CK = (CAL_CK_RAW < 1) ? 1 : CAL_CK_RAW; // RQ2

   generate
      if (CAL_CK > (1 << CAL_W) - 1 || MOD_CK < 1 ||
          MOD_CK + 2 * ((1 << CAL_W) - 1) > (1 << WAIT_W) - 1) begin : g_chk
         $error("casr_ctrl: latency or wait out of range");
      end
   endgenerate

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_HOLD = 2'b10
   } casr_ctrl_state_t;

   localparam logic [ADDR_W-1:0] CAL_MASK =
      ADDR_W'(((1 << CAL_W) - 1) << CAL_LSB);

   casr_ctrl_state_t state_reg;
   logic [CAL_W-1:0] cal_reg;
   logic [CAL_W-1:0] delay_reg;
   logic [WAIT_W-1:0] wait_reg;
   logic sr_reg;
   logic cs_n_reg;
   casr_cmd_t cmd_reg;
   casr_cmd_t pend_cmd_reg;
   logic [BA_W-1:0] ba_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic odt_reg;

   // ***********************************************
   // request decode
   // ***********************************************
   wire is_mrs = (req_cmd_in == CMD_MRS);
   wire is_mr1 = is_mrs && (req_ba_in == MR_ONE_SEL);
   wire [CAL_W-1:0] cal_field = cal_enable_in ? CAL_W'(CAL_CK) : CAL_RESET;
   wire [ADDR_W-1:0] addr_fix = is_mr1
      ? ((req_addr_in & ~CAL_MASK) | (ADDR_W'(cal_field) << CAL_LSB))
      : req_addr_in; // RQ2
   wire sr_block = sr_reg && is_mrs && (req_ba_in == MR_TWO_SEL); // RQ12
   wire idle = (state_reg == ST_IDLE);
   assign req_ready_out = idle && (wait_reg == '0) && !sr_block; // RQ5 RQ6
   wire accept = req_valid_in && req_ready_out;
   wire [CAL_W-1:0] new_cal = (accept && is_mr1) ? cal_field : cal_reg;
   wire cal_on = (cal_reg != CAL_RESET);
   // counted from acceptance, so the old latency is added on top
   wire [WAIT_W-1:0] wait_load = WAIT_W'(MOD_CK) + WAIT_W'(new_cal)
                                 + WAIT_W'(cal_reg); // RQ5 RQ6 RQ7
   wire hold_done = (delay_reg == CAL_RESET);

   // ***********************************************
   // registers
   // ***********************************************
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= ST_IDLE;
         cal_reg <= CAL_RESET;
         delay_reg <= CAL_RESET;
         wait_reg <= '0;
         sr_reg <= 1'b0;
      end else if (ce_in) begin
         if (wait_reg != '0) begin
            wait_reg <= wait_reg - WAIT_W'(1);
         end
         case (state_reg)
            ST_IDLE: begin
               if (accept) begin
                  cal_reg <= new_cal; // RQ7
                  if (is_mrs) begin
                     wait_reg <= wait_load;
                  end
                  if (req_cmd_in == CMD_SRE) begin
                     sr_reg <= 1'b1;
                  end
                  if (req_cmd_in == CMD_SRX) begin
                     sr_reg <= 1'b0;
                  end
                  if (cal_on) begin
                     delay_reg <= cal_reg - CAL_W'(1);
                     state_reg <= ST_HOLD;
                  end
               end
            end
            ST_HOLD: begin
               if (hold_done) begin
                  state_reg <= ST_IDLE;
               end else begin
                  delay_reg <= delay_reg - CAL_W'(1);
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // link drive: cs low first, command cal clocks later
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         cs_n_reg <= 1'b1;
         cmd_reg <= CMD_DES;
         pend_cmd_reg <= CMD_DES;
         ba_reg <= '0;
         addr_reg <= '0;
      end else if (ce_in) begin
         cs_n_reg <= 1'b1;
         cmd_reg <= CMD_DES;
         if (idle && accept) begin
            cs_n_reg <= 1'b0;
            ba_reg <= req_ba_in;
            addr_reg <= addr_fix;
            pend_cmd_reg <= req_cmd_in;
            if (!cal_on) begin
               cmd_reg <= req_cmd_in;
            end
         end else if (!idle && hold_done) begin
            cmd_reg <= pend_cmd_reg;
         end
      end
   end

   // termination is sent with no latency added
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         odt_reg <= 1'b0;
      end else if (ce_in) begin
         odt_reg <= odt_in; // RQ8
      end
   end

   assign link.cs_n = cs_n_reg;
   assign link.cmd = cmd_reg;
   assign link.ba = ba_reg;
   assign link.addr = addr_reg;
   assign link.odt = odt_reg;
   assign cal_out = cal_reg;
   assign self_refresh_out = sr_reg;
endmodule : casr_ctrl
`default_nettype wire

/* File: verification/casr_assertions.sv */
// link checker for the controller and dram ends of one link
// assumes the interface signals of that link and the one dram clock
`timescale 1ns/1ps
`default_nettype none
module casr_assertions
   import casr_pkg::*;
#(
   parameter int MOD_CK = MODE_UPDATE_WAIT_CK
)
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic cs_n,
   input wire casr_cmd_t cmd,
   input wire logic [BA_W-1:0] ba,
   input wire logic [ADDR_W-1:0] addr
);
   // ***********************************************
   // link state rebuilt from captured commands
   // ***********************************************
   logic [CAL_W-1:0] cal_reg;
   logic [7:0] hist_reg;
   logic [7:0] gap_reg;
   logic sr_reg;
   wire logic cap = cmd != CMD_DES;
   wire logic mrs = cmd == CMD_MRS;
   wire logic mr1 = mrs && ba == MR_ONE_SEL;
   wire logic [CAL_W-1:0] cal_next = mr1 ? addr[CAL_LSB +: CAL_W] : cal_reg;
   // pipe of chip select lows, empty while latency is off
   wire logic [7:0] hist_next = (cal_reg == 3'h0) ? 8'h00 :
      {hist_reg[6:0], !cs_n};
   wire logic [7:0] gap_next = mrs ? 8'h01 :
      ((gap_reg == 8'hFF) ? gap_reg : gap_reg + 8'h01);
   wire logic sr_next = (cmd == CMD_SRE) || (sr_reg && cmd != CMD_SRX);
   wire logic pend = (cal_reg == 3'h0) ? !cs_n : hist_reg[cal_reg - 3'h1];
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         cal_reg <= CAL_RESET;
         hist_reg <= 8'h00;
         gap_reg <= 8'hFF;
         sr_reg <= 1'b0;
      end else begin
         cal_reg <= cal_next;
         hist_reg <= hist_next;
         gap_reg <= gap_next;
         sr_reg <= sr_next;
      end
   end
   // ***********************************************
   // properties
   // ***********************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   sequence s_mr2;
      mrs && ba == MR_TWO_SEL;
   endsequence
   sequence s_srx;
      cmd == CMD_SRX;
   endsequence
   cal_capture_a: assert property (cap |-> pend)
      else $error("command without matching chip select");
   cal_follow_a: assert property (cal_reg != 3'h0 && pend |-> cap)
      else $error("chip select without delayed command");
   nocal_same_a: assert property (cal_reg == 3'h0 && !cs_n |-> cap)
      else $error("command not with chip select");
   cal_single_a: assert property (cal_reg != 3'h0 && !cs_n |=> cs_n)
      else $error("second select inside latency hold");
   field_hold_a: assert property
      (!$stable(ba) || !$stable(addr) |-> !cs_n)
      else $error("address moved without chip select");
   mrs_gap_a: assert property
      (cap |-> gap_reg >= MOD_CK + cal_reg)
      else $error("command too soon after mode command");
   sr_mr2_a: assert property (s_mr2 |-> !sr_reg)
      else $error("temperature mode written in self refresh");
   srx_order_a: assert property (s_srx |-> sr_reg)
      else $error("exit without self refresh");
   cal_cover_c: cover property (mr1 ##1 cal_reg != 3'h0);
endmodule : casr_assertions
`default_nettype wire

/* File: verification/cmd_addr_latency_self_refresh_mode_test.sv */
// bench: controller and dram ends joined by one link, with a model
// assumes the design package, interface and both ends compiled first
`timescale 1ns/1ps
`default_nettype none
module cmd_addr_latency_self_refresh_mode_test;
   import casr_pkg::*;
   localparam int CAL_TS = 20000;
   localparam int MOD = 4;
   localparam int CALC = (CAL_TS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   typedef struct {int c; int b; int a; int t;} casr_exp_t;
   logic clk_sys_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1;
   logic req_valid_in = 1'b0, cal_enable_in = 1'b0, odt_in = 1'b0;
   casr_cmd_t req_cmd_in = CMD_RD;
   logic [BA_W-1:0] req_ba_in = 2'h0;
   logic [ADDR_W-1:0] req_addr_in = 14'h0000;
   logic signed [7:0] temp_in = 8'sh00;
   wire logic ready, c_sr, d_sr, vld, rx_en, odt_o;
   wire logic [CAL_W-1:0] c_cal, d_cal;
   wire casr_cmd_t cmd_o;
   wire logic [BA_W-1:0] ba_o;
   wire logic [ADDR_W-1:0] addr_o;
   wire casr_low_power_auto_refresh_mode_t lp;
   wire casr_rate_t rate;
   int mismatches = 0, checked = 0, seed = 32'h3956, cyc = 0;
   int cal_m = 0, mode_m = 0, sr_m = 0, srm_m = 0, stab = 0;
   casr_exp_t q[$];
   casr_exp_t me;
   logic [7:0] hist = 8'h00;
   logic [1:0] odq = 2'h0;
   logic pend, o;
   casr_cmd_t tbl[3] = '{CMD_RD, CMD_WR, CMD_REF};
   logic signed [7:0] tt[4] = '{8'sh2D, 8'sh2E, 8'sh55, 8'sh56};
   casr_if link();
   casr_ctrl #(.CAL_TIME_PS(CAL_TS), .MOD_CK(MOD)) casr_ctrl_i (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
      .link(link), .req_valid_in(req_valid_in), .req_cmd_in(req_cmd_in),
      .req_ba_in(req_ba_in), .req_addr_in(req_addr_in),
      .cal_enable_in(cal_enable_in), .odt_in(odt_in),
      .req_ready_out(ready), .cal_out(c_cal), .self_refresh_out(c_sr));
   casr_dram casr_dram_i (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
      .link(link), .temp_in(temp_in), .cmd_valid_out(vld),
      .cmd_out(cmd_o), .ba_out(ba_o), .addr_out(addr_o),
      .rx_en_out(rx_en), .odt_out(odt_o), .cal_out(d_cal),
      .low_power_auto_refresh_mode_mode_out(lp), .self_refresh_out(d_sr), .sr_rate_out(rate));
   casr_assertions #(.MOD_CK(MOD)) casr_assertions_i (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cs_n(link.cs_n),
      .cmd(link.cmd), .ba(link.ba), .addr(link.addr));
   initial begin
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) cyc <= cyc + 1;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // leaves valid high so requests can chain; idle_wait() drops it
   task automatic req(input casr_cmd_t c, input logic [BA_W-1:0] b,
      input logic [ADDR_W-1:0] a);
      int i;
      casr_exp_t e;
      req_valid_in = 1'b1;
      req_cmd_in = c;
      req_ba_in = b;
      req_addr_in = a;
      // let the ready decode settle on the new request before looking
      #1;
      for (i = 0; i < 400 && ready !== 1'b1; i++) @(negedge clk_sys_in);
      if (i == 400) begin
         mismatches++;
         tally_and_finish();
      end
      @(negedge clk_sys_in);
      e = '{int'(c), int'(b), int'(a), cyc};
      if (c == CMD_MRS && b == MR_ONE_SEL) begin
         e.a = (a & ~(7 << CAL_LSB)) | ((cal_enable_in ? CALC : 0) << CAL_LSB);
      end
      q.push_back(e);
   endtask : req
   task automatic idle_wait();
      int i;
      req_valid_in = 1'b0;
      for (i = 0; i < 300 && q.size() > 0; i++) @(negedge clk_sys_in);
      if (i == 300) begin
         mismatches++;
         tally_and_finish();
      end
      repeat (4) @(negedge clk_sys_in);
   endtask : idle_wait
   task automatic rate_chk();
      int m, t, r;
      m = sr_m ? srm_m : mode_m;
      t = temp_in;
      r = (m == 3) ? (t <= TEMP_COLD_MAX ? 1 : (t > TEMP_NORMAL_MAX ? 4 : 2))
         : (m == 2 ? 4 : (m == 1 ? 1 : 2));
      repeat (6) @(negedge clk_sys_in);
      check(16'(rate), 16'(r));
      check(16'(lp), 16'(mode_m));
   endtask : rate_chk
   // ***********************************************
   // model compare at every capture, receivers and odt each cycle once 8 cycles past reset, ce low or a latency write
   // ***********************************************
   always @(negedge clk_sys_in) begin
      if (rst_in || !ce_in) begin
         stab = 0;
      end else begin
         if (vld === 1'b1) begin
            if (q.size() == 0) begin
               check(16'h0000, 16'h0001);
            end else begin
               me = q.pop_front();
               check(16'(cmd_o), 16'(me.c));
               check(16'(ba_o), 16'(me.b));
               check(16'(addr_o), 16'(me.a));
               check(16'(cyc - me.t), 16'(1 + cal_m));
               if (me.c == CMD_MRS && me.b == MR_ONE_SEL) begin
                  cal_m = (me.a >> CAL_LSB) & 7;
                  stab = 0;
               end
               if (me.c == CMD_MRS && me.b == MR_TWO_SEL) begin
                  mode_m = (me.a >> LOW_POWER_AUTO_REFRESH_MODE_LSB) & 3;
               end
               if (me.c == CMD_SRE) begin
                  sr_m = 1;
                  srm_m = mode_m;
               end
               if (me.c == CMD_SRX) sr_m = 0;
            end
         end
         if (stab >= 8) begin
            pend = !link.cs_n;
            for (int k = 0; k < cal_m; k++) pend = pend | hist[k];
            check(16'(rx_en), 16'(pend || cal_m == 0));
            check(16'(odt_o), 16'(odq[1]));
         end
         stab++;
      end
      o = cyc[0] ^ cyc[2];
      hist <= {hist[6:0], !link.cs_n};
      odq <= {odq[0], o};
      odt_in <= o;
   end
   initial begin
      repeat (10) @(negedge clk_sys_in);
      rst_in = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      for (int i = 0; i < 6; i++) begin
         req(tbl[i % 3], 2'($random(seed)), 14'($random(seed)));
      end
      idle_wait();
      $display("test back to back without latency done");
      cal_enable_in = 1'b1;
      req(CMD_MRS, MR_ONE_SEL, 14'($random(seed)));
      req(CMD_RD, 2'h3, 14'($random(seed)));
      req(CMD_MRS, MR_TWO_SEL, 14'h0080);
      req(CMD_WR, 2'h0, 14'($random(seed)));
      idle_wait();
      check(16'(c_cal), 16'(CALC));
      check(16'(d_cal), 16'(CALC));
      rate_chk();
      cal_enable_in = 1'b0;
      req(CMD_MRS, MR_ONE_SEL, 14'($random(seed)));
      req(CMD_RD, 2'h1, 14'($random(seed)));
      idle_wait();
      check(16'(d_cal), 16'h0000);
      $display("test latency on and off done");
      for (int m = 0; m < 4; m++) begin
         req(CMD_MRS, MR_TWO_SEL, 14'(m << LOW_POWER_AUTO_REFRESH_MODE_LSB));
         idle_wait();
         for (int j = 0; j < 8; j++) begin
            temp_in = (j < 4) ? tt[j] : 8'($random(seed));
            rate_chk();
         end
      end
      $display("test temperature modes done");
      temp_in = tt[0];
      rate_chk();
      ce_in = 1'b0;
      temp_in = tt[3];
      repeat (6) @(negedge clk_sys_in);
      check(16'(rate), 16'(RATE_LOW));
      ce_in = 1'b1;
      rate_chk();
      $display("test clock enable freeze done");
      req(CMD_MRS, MR_TWO_SEL, 14'h0080);
      req(CMD_SRE, 2'h0, 14'h0000);
      idle_wait();
      check(16'(c_sr), 16'h0001);
      check(16'(d_sr), 16'h0001);
      temp_in = 8'sh10;
      rate_chk();
      req_valid_in = 1'b1;
      req_cmd_in = CMD_MRS;
      req_ba_in = MR_TWO_SEL;
      req_addr_in = 14'h00C0;
      #1;
      repeat (8) begin
         check(16'(ready), 16'h0000);
         @(negedge clk_sys_in);
      end
      req_valid_in = 1'b0;
      @(negedge clk_sys_in);
      req(CMD_SRX, 2'h0, 14'h0000);
      idle_wait();
      check(16'(d_sr), 16'h0000);
      $display("test self refresh done");
      tally_and_finish();
   end
endmodule : cmd_addr_latency_self_refresh_mode_test
`default_nettype wire
